// ### verilog/pbs_sram_dev.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Processor strobe with selects starts read burst
// - Controller strobe starts write or read burst
// - Continue read at next address, drive per enable
// - Continue write at next address, enable ignored
// - Advance high repeats read at current address
// - Advance high repeats write at current address
// - Write when gate plus lane, or global low
// - All write inputs high means read
// - Lane enable writes own byte and parity
// - Parity lanes exist per configured width
// - Inputs other than sleep and output enable sampled on rising edge, host holds
// - Host pauses burst by suspend cycles
// - Host releases output enable around write data
// - Data outputs float from power-up
// - Processor strobe reads; write follows next edge
// - Interleaved order XORs start address
// - Linear order increments modulo four
// - Any subset of lanes writes exactly those
module pbs_sram_dev import pbs_pkg::*; #(
  parameter int ADDR_W = PBS_ADDR_W,
  parameter int LANES = PBS_LANES,
  parameter int LANE_W = PBS_LANE_W,
  parameter int PAR_LANES = PBS_PAR_LANES
) (
  // Clock
  input wire logic sys_clk,
  // Link
  pbs_link_if.dev link,
  // Status
  output logic sleeping,
  output logic powered_down
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int WORD_W = LANES * LANE_W;

  logic [WORD_W-1:0] mem [DEPTH];
  logic [PAR_LANES-1:0] pmem [DEPTH];
  logic [ADDR_W-1:0] base_addr = '0;
  logic [1:0] burst_cnt = PBS_CNT_RESET;
  logic active = 1'b0;
  logic rd_pending = 1'b0;
  logic [WORD_W-1:0] rd_data = '0;
  logic [PAR_LANES-1:0] rd_par = '0;
  logic [1:0] low_bits;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] next_addr;
  logic [1:0] next_cnt;
  logic sel_ok;
  logic write_req;
  logic [LANES-1:0] lane_wr;
  pbs_cycle_e cyc;

  // Combined write decode
  always_comb begin
    lane_wr = '0;
    if (!link.global_write_all) begin
      lane_wr = '1;
    end else if (!link.byte_write_gate) begin
      lane_wr = ~link.lane_write_enables;
    end
  end
  assign write_req = |lane_wr;

  // All three selects must agree before a strobe may start a burst
  assign sel_ok = !link.select_active_low && !link.second_select_low && link.third_select_high;

  // Cycle classification, all inputs taken at the rising edge
  always_comb begin
    if (link.sleep_request) begin
      cyc = PBS_CYC_SLEEP;
    end else if (!link.processor_address_strobe && !link.select_active_low) begin
      cyc = sel_ok ? PBS_CYC_BEGIN : PBS_CYC_DESELECT;
    end else if (!link.controller_address_strobe) begin
      cyc = sel_ok ? PBS_CYC_BEGIN : PBS_CYC_DESELECT;
    end else if (!active) begin
      cyc = PBS_CYC_DESELECT;
    end else if (!link.burst_advance) begin
      cyc = PBS_CYC_CONTINUE;
    end else begin
      cyc = PBS_CYC_SUSPEND;
    end
  end

  // Burst counter order
  always_comb begin
    next_cnt = burst_cnt + PBS_STEP1;
    if (link.burst_order_select) begin
      low_bits = base_addr[1:0] ^ next_cnt;
    end else begin
      low_bits = base_addr[1:0] + next_cnt;
    end
    next_addr = {base_addr[ADDR_W-1:2], low_bits};
  end

  // Address of this cycle's access
  always_comb begin
    if (cyc == PBS_CYC_BEGIN) begin
      cur_addr = link.addr;
    end else if (cyc == PBS_CYC_CONTINUE) begin
      cur_addr = next_addr;
    end else begin
      cur_addr = burst_active_addr(base_addr, burst_cnt, link.burst_order_select);
    end
  end

  // Address of the current beat, held through a suspend
  function automatic logic [ADDR_W-1:0] burst_active_addr(
    input logic [ADDR_W-1:0] b,
    input logic [1:0] c,
    input logic ord
  );
    logic [1:0] lb;
    lb = ord ? (b[1:0] ^ c) : (b[1:0] + c);
    return {b[ADDR_W-1:2], lb};
  endfunction

  // Burst base address, loaded only when a burst begins
  always_ff @(posedge sys_clk) begin
    if (cyc == PBS_CYC_BEGIN) begin
      base_addr <= link.addr;
    end
  end

  // Burst counter: a suspend holds it so a repeated access hits the same word
  always_ff @(posedge sys_clk) begin
    case (cyc)
      PBS_CYC_BEGIN: begin
        burst_cnt <= PBS_CNT_RESET;
      end
      PBS_CYC_CONTINUE: begin
        burst_cnt <= next_cnt;
      end
      default: begin
        burst_cnt <= burst_cnt;
      end
    endcase
  end

  // Burst in progress; deselect and sleep both drop into power-down
  always_ff @(posedge sys_clk) begin
    case (cyc)
      PBS_CYC_BEGIN: begin
        active <= 1'b1;
      end
      PBS_CYC_DESELECT, PBS_CYC_SLEEP: begin
        active <= 1'b0;
      end
      default: begin
        active <= active;
      end
    endcase
  end

  // A processor strobe always reads; the write lands on the next edge
  // as a continue or suspend cycle with the write inputs low.
  logic do_write;
  assign do_write = write_req && (cyc == PBS_CYC_CONTINUE || cyc == PBS_CYC_SUSPEND ||
    (cyc == PBS_CYC_BEGIN && link.processor_address_strobe));

  // Array write per lane; a lane left out keeps its byte and parity bit
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (do_write && lane_wr[i]) begin
        mem[cur_addr][i*LANE_W +: LANE_W] <= link.data_from_host[i*LANE_W +: LANE_W];
      end
    end
    for (int p = 0; p < PAR_LANES; p++) begin
      if (do_write && p < LANES && lane_wr[p]) begin
        pmem[cur_addr][p] <= link.par_from_host[p];
      end
    end
  end

  // Read flag of the output pipeline. An unknown cycle code falls to the
  // else branch, so the bus stays released while the inputs settle.
  always_ff @(posedge sys_clk) begin
    if (cyc == PBS_CYC_BEGIN || cyc == PBS_CYC_CONTINUE ||
        cyc == PBS_CYC_SUSPEND) begin
      rd_pending <= !do_write;
    end else begin
      rd_pending <= 1'b0;
    end
  end

  // The array is read on every edge; rd_pending, output enable and sleep decide whether it shows
  always_ff @(posedge sys_clk) begin
    rd_data <= mem[cur_addr];
  end

  always_ff @(posedge sys_clk) begin
    rd_par <= pmem[cur_addr];
  end

  // Sleep and output enable act without the clock, so a host may
  // release the bus at once without waiting for an edge.
  assign link.dev_data_oe = rd_pending && !link.output_drive_enable
    && !link.sleep_request;
  assign link.data_from_dev = rd_data;
  assign link.par_from_dev = rd_par;
  assign sleeping = link.sleep_request;
  assign powered_down = !active;
endmodule // pbs_sram_dev

// ### verilog/pbs_pkg.sv
package pbs_pkg;
  localparam int PBS_ADDR_W = 8;
  localparam int PBS_LANES = 4;
  localparam int PBS_LANE_W = 8;
  localparam int PBS_PAR_LANES = 4;
  localparam int PBS_FIFO_DEPTH = 4;
  localparam int PBS_BURST_LEN = 4;
  localparam logic [1:0] PBS_CNT_RESET = 2'h0;
  localparam logic [1:0] PBS_STEP1 = 2'h1;

  typedef enum logic [2:0] {
    PBS_CYC_DESELECT = 3'b000,
    PBS_CYC_SLEEP = 3'b001,
    PBS_CYC_BEGIN = 3'b010,
    PBS_CYC_CONTINUE = 3'b011,
    PBS_CYC_SUSPEND = 3'b100
  } pbs_cycle_e;

  typedef enum logic [1:0] {
    PBS_HS_IDLE = 2'b00,
    PBS_HS_START = 2'b01,
    PBS_HS_BURST = 2'b10,
    PBS_HS_WRITE = 2'b11
  } pbs_host_state_e;
endpackage

// ### verilog/pbs_link_if.sv
`timescale 1ns/1ns
interface pbs_link_if #(
  parameter int ADDR_W = 8,
  parameter int LANES = 4,
  parameter int LANE_W = 8,
  parameter int PAR_LANES = 4
);
  logic [ADDR_W-1:0] addr;
  logic select_active_low;
  logic second_select_low;
  logic third_select_high;
  logic sleep_request;
  logic processor_address_strobe;
  logic controller_address_strobe;
  logic burst_advance;
  logic global_write_all;
  logic byte_write_gate;
  logic [LANES-1:0] lane_write_enables;
  logic output_drive_enable;
  logic burst_order_select;
  logic [LANES*LANE_W-1:0] data_from_host;
  logic [LANES*LANE_W-1:0] data_from_dev;
  logic [PAR_LANES-1:0] par_from_host;
  logic [PAR_LANES-1:0] par_from_dev;
  logic host_data_oe;
  logic dev_data_oe;

  modport dev (
    input addr, select_active_low, second_select_low, third_select_high, sleep_request,
    input processor_address_strobe, controller_address_strobe, burst_advance,
    input global_write_all, byte_write_gate, lane_write_enables, output_drive_enable,
    input burst_order_select, data_from_host, par_from_host, host_data_oe,
    output data_from_dev, par_from_dev, dev_data_oe
  );
  modport host (
    output addr, select_active_low, second_select_low, third_select_high, sleep_request,
    output processor_address_strobe, controller_address_strobe, burst_advance,
    output global_write_all, byte_write_gate, lane_write_enables, output_drive_enable,
    output burst_order_select, data_from_host, par_from_host, host_data_oe,
    input data_from_dev, par_from_dev, dev_data_oe
  );
endinterface

// ### verilog/pbs_fifo.sv
`timescale 1ns/1ns
module pbs_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = count != DEPTH[PW:0];
  assign out_valid = count != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = store[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // pbs_fifo

// ### verilog/pbs_host_ctrl.sv
`timescale 1ns/1ns
module pbs_host_ctrl import pbs_pkg::*; #(
  parameter int ADDR_W = PBS_ADDR_W,
  parameter int LANES = PBS_LANES,
  parameter int LANE_W = PBS_LANE_W,
  parameter int PAR_LANES = PBS_PAR_LANES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [LANES-1:0] req_lanes,
  input wire logic [LANES*LANE_W-1:0] req_wdata,
  input wire logic [PAR_LANES-1:0] req_wpar,
  input wire logic linear_order,
  input wire logic sleep,
  // Read answer
  output logic rsp_valid,
  output logic [LANES*LANE_W-1:0] rsp_data,
  output logic [PAR_LANES-1:0] rsp_par,
  // Link
  pbs_link_if.host link
);
  localparam int WORD_W = LANES * LANE_W;
  localparam int FW = ADDR_W + 1 + LANES + WORD_W + PAR_LANES;
  logic f_valid;
  logic f_ready;
  logic [FW-1:0] f_data;
  pbs_host_state_e state;
  logic [1:0] rd_wait;

  pbs_fifo #(.WIDTH(FW), .DEPTH(PBS_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_addr, req_write, req_lanes, req_wdata, req_wpar}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Single-word accesses via controller strobe; stalls while sleeping
  assign f_ready = (state == PBS_HS_IDLE) && !sleep;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= PBS_HS_IDLE;
      link.controller_address_strobe <= 1'b1;
      link.processor_address_strobe <= 1'b1;
      link.select_active_low <= 1'b1;
      link.second_select_low <= 1'b1;
      link.third_select_high <= 1'b0;
      link.burst_advance <= 1'b1;
      link.global_write_all <= 1'b1;
      link.byte_write_gate <= 1'b1;
      link.lane_write_enables <= '1;
      link.output_drive_enable <= 1'b1;
      link.host_data_oe <= 1'b0;
      link.addr <= '0;
      link.data_from_host <= '0;
      link.par_from_host <= '0;
    end else begin
      link.controller_address_strobe <= 1'b1;
      link.select_active_low <= 1'b1;
      link.lane_write_enables <= '1;
      link.byte_write_gate <= 1'b1;
      link.host_data_oe <= 1'b0;
      case (state)
        PBS_HS_IDLE: begin
          if (f_valid && f_ready) begin
            link.addr <= f_data[FW-1 -: ADDR_W];
            link.controller_address_strobe <= 1'b0;
            link.select_active_low <= 1'b0;
            link.second_select_low <= 1'b0;
            link.third_select_high <= 1'b1;
            if (f_data[FW-1-ADDR_W]) begin
              link.output_drive_enable <= 1'b1;
              link.byte_write_gate <= 1'b0;
              link.lane_write_enables <= ~f_data[WORD_W+PAR_LANES +: LANES];
              link.data_from_host <= f_data[PAR_LANES +: WORD_W];
              link.par_from_host <= f_data[PAR_LANES-1:0];
              link.host_data_oe <= 1'b1;
              // No lane selected is a read on the link and needs read spacing
              state <= (|f_data[WORD_W+PAR_LANES +: LANES]) ? PBS_HS_WRITE : PBS_HS_START;
            end else begin
              link.output_drive_enable <= 1'b0;
              state <= PBS_HS_START;
            end
          end
        end
        PBS_HS_START: state <= PBS_HS_BURST;
        default: state <= PBS_HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_wait <= rst ? 2'h0 : {rd_wait[0], state == PBS_HS_START && !link.host_data_oe};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_par <= '0;
    end else begin
      rsp_valid <= rd_wait[0];
      if (rd_wait[0]) begin
        rsp_data <= link.data_from_dev;
        rsp_par <= link.par_from_dev;
      end
    end
  end

  assign link.sleep_request = sleep;
  assign link.burst_order_select = !linear_order;
endmodule // pbs_host_ctrl

// ### verif/pbs_link_monitor.sv
`timescale 1ns/1ns
module pbs_link_monitor #(
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link controls
  input wire logic select_active_low,
  input wire logic sleep_request,
  input wire logic processor_address_strobe,
  input wire logic controller_address_strobe,
  input wire logic global_write_all,
  input wire logic byte_write_gate,
  input wire logic [LANES-1:0] lane_write_enables,
  input wire logic output_drive_enable,
  // Data drivers
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  wire logic write_low = !global_write_all || (!byte_write_gate && !(&lane_write_enables));

  sequence deselect_s;
    select_active_low && !controller_address_strobe;
  endsequence
  sequence write_start_s;
    !controller_address_strobe && write_low;
  endsequence
  sequence read_start_s;
    !controller_address_strobe && !write_low;
  endsequence

  AST_SLEEP_FLOAT: assert property (sleep_request |-> !dev_data_oe)
    else $error("data driven while asleep");
  AST_OE_FLOAT: assert property (output_drive_enable |-> !dev_data_oe)
    else $error("data driven with output enable high");
  AST_NO_CLASH: assert property (host_data_oe |-> output_drive_enable && !dev_data_oe)
    else $error("host drives data while output enable low");
  AST_WRITE_DATA: assert property (write_start_s |-> host_data_oe)
    else $error("write started without host data");
  AST_DESELECT: assert property (deselect_s ##1 deselect_s |=> !dev_data_oe)
    else $error("data driven after deselect");
  AST_WRITE_GAP: assert property (write_start_s |=> controller_address_strobe)
    else $error("write strobe held longer than one cycle");
  AST_READ_GAP: assert property (read_start_s |=> controller_address_strobe [*2])
    else $error("read strobes closer than three cycles");
  AST_READ_DRIVE: assert property (read_start_s ##1
      (!output_drive_enable && !sleep_request && !write_low) [*2] |-> dev_data_oe)
    else $error("read data not driven");
endmodule // pbs_link_monitor

// ### verif/pipelined_burst_sram_port_tb.sv
`timescale 1ns/1ns
module pipelined_burst_sram_port_tb import pbs_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [3:0] req_lanes = 4'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0] req_wpar = 4'h0;
  logic linear_order = 1'b0;
  logic sleep = 1'b0;
  logic req_ready, rsp_valid, sleeping, powered_down;
  logic [31:0] rsp_data;
  logic [3:0] rsp_par;
  logic [35:0] rq[$];
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;

  always #50 sys_clk = ~sys_clk;

  pbs_link_if i_pbs_link_if ();
  pbs_sram_dev i_pbs_sram_dev (.sys_clk(sys_clk), .link(i_pbs_link_if.dev),
    .sleeping(sleeping), .powered_down(powered_down));
  pbs_host_ctrl i_pbs_host_ctrl (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_lanes(req_lanes),
    .req_wdata(req_wdata), .req_wpar(req_wpar), .linear_order(linear_order), .sleep(sleep),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_par(rsp_par), .link(i_pbs_link_if.host));
  pbs_link_monitor #(.LANES(PBS_LANES)) i_pbs_link_monitor (.sys_clk(sys_clk), .rst(rst),
    .select_active_low(i_pbs_link_if.select_active_low),
    .sleep_request(i_pbs_link_if.sleep_request),
    .processor_address_strobe(i_pbs_link_if.processor_address_strobe),
    .controller_address_strobe(i_pbs_link_if.controller_address_strobe),
    .global_write_all(i_pbs_link_if.global_write_all),
    .byte_write_gate(i_pbs_link_if.byte_write_gate),
    .lane_write_enables(i_pbs_link_if.lane_write_enables),
    .output_drive_enable(i_pbs_link_if.output_drive_enable),
    .host_data_oe(i_pbs_link_if.host_data_oe), .dev_data_oe(i_pbs_link_if.dev_data_oe));

  // Answers are queued so a stalled drain can be collected later
  always @(posedge sys_clk) begin
    if (rsp_valid === 1'b1) rq.push_back({rsp_par, rsp_data});
  end

  task automatic results();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic push(input logic w, input logic [7:0] a, input logic [3:0] l,
                      input logic [31:0] d, input logic [3:0] p);
    req_write <= w;
    req_addr <= a;
    req_lanes <= l;
    req_wdata <= d;
    req_wpar <= p;
    req_valid <= 1'b1;
    do @(posedge sys_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic read(input logic [7:0] a, output logic [35:0] got);
    int k;
    k = 0;
    push(1'b0, a, 4'h0, 32'h0, 4'h0);
    while (rq.size() == 0 && k < 30) begin
      @(posedge sys_clk);
      k++;
    end
    got = (rq.size() > 0) ? rq.pop_front() : 36'hX_XXXX_XXXX;
  endtask

  task automatic t_write_read();
    logic [35:0] got;
    push(1'b1, 8'h10, 4'hF, 32'h0123_4567, 4'hA);
    read(8'h10, got);
    chk(got, {4'hA, 32'h0123_4567}, "full word");
    linear_order <= 1'b1;
    read(8'h10, got);
    chk(got, {4'hA, 32'h0123_4567}, "reread");
    linear_order <= 1'b0;
    $display("test write_read done");
  endtask

  task automatic t_lanes();
    logic [35:0] got;
    push(1'b1, 8'h21, 4'hF, 32'hAABB_CCDD, 4'hF);
    push(1'b1, 8'h21, 4'h5, 32'h1122_3344, 4'h0);
    // No lane selected must leave the word alone
    push(1'b1, 8'h21, 4'h0, 32'h0, 4'h0);
    read(8'h21, got);
    chk(got, {4'hA, 32'hAA22_CC44}, "lane subset");
    $display("test lanes done");
  endtask

  task automatic t_sleep_fifo();
    int n;
    n = 0;
    sleep <= 1'b1;
    @(posedge sys_clk);
    req_write <= 1'b0;
    req_addr <= 8'h10;
    req_valid <= 1'b1;
    repeat (8) begin
      @(posedge sys_clk);
      if (req_ready === 1'b1) n++;
    end
    req_valid <= 1'b0;
    chk(36'(n), 36'(PBS_FIFO_DEPTH), "fifo fill");
    chk({35'h0, sleeping}, 36'h1, "sleeping");
    chk({35'h0, i_pbs_link_if.dev_data_oe}, 36'h0, "float in sleep");
    sleep <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk(36'(rq.size()), 36'(PBS_FIFO_DEPTH), "drained");
    while (rq.size() > 0) chk(rq.pop_front(), {4'hA, 32'h0123_4567}, "drain data");
    $display("test sleep_fifo done");
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({35'h0, i_pbs_link_if.dev_data_oe}, 36'h0, "power-up float");
    chk({35'h0, powered_down}, 36'h1, "idle power-down");
    t_write_read();
    t_lanes();
    t_sleep_fifo();
    results();
  end
endmodule // pipelined_burst_sram_port_tb
